// ---- verilog/tws_pkg.sv ----
package tws_pkg;

  // ----------------------------------------------------------------
  // register addresses on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL = 8'hD8;
  localparam logic [7:0] ADDR_STA = 8'hD9;
  localparam logic [7:0] ADDR_DAT = 8'hDA;
  localparam logic [7:0] ADDR_ADR = 8'hDB;

  // ----------------------------------------------------------------
  // control and address field positions, reset values
  // ----------------------------------------------------------------
  localparam int B_CR2 = 7;
  localparam int B_ENS = 6;
  localparam int B_STA = 5;
  localparam int B_STO = 4;
  localparam int B_SI = 3;
  localparam int B_AA = 2;
  localparam int B_CR1 = 1;
  localparam int B_CR0 = 0;
  localparam int B_GC = 0;
  localparam int SC_LSB = 3;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] ADR_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [6:0] GC_ADDR = 7'h00;

  // ----------------------------------------------------------------
  // state codes, low three bits always zero
  // ----------------------------------------------------------------
  localparam logic [7:0] S_START = 8'h08;
  localparam logic [7:0] S_RSTART = 8'h10;
  localparam logic [7:0] S_MT_SLA_ACK = 8'h18;
  localparam logic [7:0] S_MT_SLA_NAK = 8'h20;
  localparam logic [7:0] S_MT_DAT_ACK = 8'h28;
  localparam logic [7:0] S_MT_DAT_NAK = 8'h30;
  localparam logic [7:0] S_ARB_LOST = 8'h38;
  localparam logic [7:0] S_MR_SLA_ACK = 8'h40;
  localparam logic [7:0] S_MR_SLA_NAK = 8'h48;
  localparam logic [7:0] S_MR_DAT_ACK = 8'h50;
  localparam logic [7:0] S_MR_DAT_NAK = 8'h58;
  localparam logic [7:0] S_SR_SLA = 8'h60;
  localparam logic [7:0] S_SR_GC = 8'h70;
  localparam logic [7:0] S_SR_DAT_ACK = 8'h80;
  localparam logic [7:0] S_SR_DAT_NAK = 8'h88;
  localparam logic [7:0] S_SR_GCD_ACK = 8'h90;
  localparam logic [7:0] S_SR_GCD_NAK = 8'h98;
  localparam logic [7:0] S_SR_STOP = 8'hA0;
  localparam logic [7:0] S_ST_SLA = 8'hA8;
  localparam logic [7:0] S_ST_DAT_ACK = 8'hB8;
  localparam logic [7:0] S_ST_DAT_NAK = 8'hC0;
  localparam logic [7:0] S_IDLE = 8'hF8;

  // ----------------------------------------------------------------
  // byte framing, buffering and bit-rate
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam int DIV_W = 9;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tws_sfr_req_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_GEN_START, ST_HOLD, ST_M_LOW, ST_M_HIGH, ST_RS1, ST_RS2, ST_STOP1
  } tws_fsm_t;

  // half of the oscillator divisor: each scl phase lasts this many clocks
  function automatic logic [DIV_W-1:0] half_div(input logic [2:0] rate);
    case (rate)
      3'h0: half_div = 9'h080;
      3'h1: half_div = 9'h070;
      3'h2: half_div = 9'h060;
      3'h3: half_div = 9'h050;
      3'h4: half_div = 9'h1E0;
      3'h5: half_div = 9'h03C;
      3'h6: half_div = 9'h01E;
      default: half_div = 9'h080;
    endcase
  endfunction : half_div

endpackage : tws_pkg

// ---- verilog/tws_fifo.sv ----
module tws_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } tws_fifo_st_t;

  tws_fifo_st_t st_reg;
  tws_fifo_st_t st_next;
  logic [AW:0] fill;

  always_comb begin
    st_next = st_reg;
    fill = st_reg.wp - st_reg.rp;
    in_ready = fill != (AW+1)'(D);
    out_valid = st_reg.wp != st_reg.rp;
    out_data = st_reg.mem[st_reg.rp[AW-1:0]];
    if (in_valid && in_ready) begin
      st_next.mem[st_reg.wp[AW-1:0]] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : tws_fifo

// ---- verilog/tws_rate_div.sv ----
module tws_rate_div (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [2:0] rate,
  output logic tick
);
  typedef struct packed {
    logic [tws_pkg::DIV_W-1:0] cnt;
    logic tick;
  } tws_div_st_t;

  tws_div_st_t st_reg;
  tws_div_st_t st_next;

  // the count restarts whenever run drops, so each phase is a full half period
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == tws_pkg::DIV_W'(tws_pkg::half_div(rate) - 9'h001)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule : tws_rate_div

// ---- verilog/tws_two_wire_unit.sv ----
// Notes on behaviour
// - data and clock lines are shared with port bits seven and six.
// - shifting, clock making, address match and arbitration run in hardware.
// - control register at D8H: rate2, enable, start, stop, flag, ack, rate1, rate0.
// - three rate bits pick the generated clock, used only as master.
// - enable low releases both lines; pins act as open-drain port bits.
// - start request as slave waits for a free bus, then sends START.
// - start request while master gives a repeated START.
// - stop request as master sends STOP; bit clears when STOP is seen.
// - stop request as slave sends nothing, releases lines, becomes unaddressed.
// - flag set after own START, own address with ack, or slave data byte.
// - flag set on general call when its enable and ack enable are one.
// - as master the flag rises after every byte, even after lost arbitration.
// - ack enable pulls data low in ack slot after address or received data.
// - ack enable low gives no ack and no flag on address match.
// - received address is compared with the own address register in hardware.
// - status register gives a unique code per bus state.
// - rate codes divide by 256,224,192,160,960,120,60; code seven not allowed.
// - status holds a five bit code in bits seven to three, low bits zero.
// - status reads F8H when nothing relevant and the flag is clear.
// - bytes move most significant bit first.
module tws_two_wire_unit (
  input wire logic clk,
  input wire logic rstn,
  input wire tws_pkg::tws_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic port_sda_latch,
  input wire logic port_scl_latch,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] adr;
    logic [7:0] shf;
    logic [7:0] rdata;
    logic [4:0] sc;
    tws_pkg::tws_fsm_t fsm;
    logic [3:0] bitc;
    logic mst;
    logic trx;
    logic addr_ph;
    logic addressed;
    logic gcm;
    logic arb;
    logic busy;
    logic rep;
    logic pend;
    logic ackbit;
    logic sda_lo;
    logic scl_lo;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic pin_lvl;
    logic sda_oe;
    logic scl_oe;
  } tws_main_st_t;

  localparam tws_main_st_t RST_VAL = '{
    ctl: tws_pkg::CTL_RST,
    adr: tws_pkg::ADR_RST,
    shf: tws_pkg::DAT_RST,
    rdata: 8'h00,
    sc: tws_pkg::S_IDLE[7:tws_pkg::SC_LSB],
    fsm: tws_pkg::ST_IDLE,
    bitc: 4'h0,
    sda_s1: 1'b1,
    sda_s2: 1'b1,
    sda_s3: 1'b1,
    scl_s1: 1'b1,
    scl_s2: 1'b1,
    scl_s3: 1'b1,
    default: 1'b0
  };

  tws_main_st_t st_reg;
  tws_main_st_t st_next;

  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic engaged;
  logic byte_done;
  logic set_si;
  logic ack;
  logic hit_own;
  logic hit_gc;
  logic [7:0] code;
  logic div_run;
  logic div_tick;
  logic fifo_pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  tws_rate_div u_div (
    .clk(clk),
    .rstn(rstn),
    .run(div_run),
    .rate({st_reg.ctl[tws_pkg::B_CR2], st_reg.ctl[tws_pkg::B_CR1],
           st_reg.ctl[tws_pkg::B_CR0]}),
    .tick(div_tick)
  );

  // received bytes queue here; a full queue keeps the clock stretched
  tws_fifo #(
    .W(tws_pkg::FIFO_W),
    .D(tws_pkg::FIFO_D)
  ) u_rx_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(st_reg.pend),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.shf),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    set_si = 1'b0;
    byte_done = 1'b0;
    code = {st_reg.sc, 3'h0};
    ack = !st_reg.ackbit;
    hit_own = st_reg.shf[7:1] == st_reg.adr[7:1];
    hit_gc = (st_reg.shf[7:1] == tws_pkg::GC_ADDR) && st_reg.adr[tws_pkg::B_GC];

    // the first stage feeds only the second
    st_next.sda_s1 = sda_in;
    st_next.sda_s2 = st_reg.sda_s1;
    st_next.sda_s3 = st_reg.sda_s2;
    st_next.scl_s1 = scl_in;
    st_next.scl_s2 = st_reg.scl_s1;
    st_next.scl_s3 = st_reg.scl_s2;
    rise = st_reg.scl_s2 && !st_reg.scl_s3;
    fall = !st_reg.scl_s2 && st_reg.scl_s3;
    start_det = st_reg.scl_s2 && st_reg.scl_s3 && !st_reg.sda_s2 && st_reg.sda_s3;
    stop_det = st_reg.scl_s2 && st_reg.scl_s3 && st_reg.sda_s2 && !st_reg.sda_s3;
    engaged = st_reg.mst || st_reg.arb || st_reg.addressed || st_reg.addr_ph;

    div_run = st_reg.ctl[tws_pkg::B_ENS] && st_reg.fsm != tws_pkg::ST_IDLE
      && st_reg.fsm != tws_pkg::ST_HOLD;
    // high phases count only once the line is seen high, so slow slaves can stretch
    if ((st_reg.fsm == tws_pkg::ST_M_HIGH || st_reg.fsm == tws_pkg::ST_RS2) && !st_reg.scl_s2)
      begin
      div_run = 1'b0;
    end

    if (st_reg.pend && fifo_in_ready) begin
      st_next.pend = 1'b0;
    end

    if (!st_reg.ctl[tws_pkg::B_ENS]) begin
      // disabled: serial logic idle, lines released
      st_next.fsm = tws_pkg::ST_IDLE;
      st_next.mst = 1'b0;
      st_next.trx = 1'b0;
      st_next.arb = 1'b0;
      st_next.addr_ph = 1'b0;
      st_next.addressed = 1'b0;
      st_next.busy = 1'b0;
      st_next.bitc = 4'h0;
      st_next.sda_lo = 1'b0;
      st_next.scl_lo = 1'b0;
    end else begin
      // ----------------------------------------------------------------
      // master sequencing
      // ----------------------------------------------------------------
      case (st_reg.fsm)
        tws_pkg::ST_IDLE: begin
          if (st_reg.ctl[tws_pkg::B_STA] && !st_reg.mst && !st_reg.busy && !engaged) begin
            st_next.fsm = tws_pkg::ST_GEN_START;
            st_next.sda_lo = 1'b1;
            st_next.rep = 1'b0;
          end
        end
        tws_pkg::ST_GEN_START: begin
          if (div_tick) begin
            st_next.scl_lo = 1'b1;
            st_next.mst = 1'b1;
            st_next.trx = 1'b1;
            st_next.fsm = tws_pkg::ST_HOLD;
            code = st_reg.rep ? tws_pkg::S_RSTART : tws_pkg::S_START;
            set_si = 1'b1;
          end
        end
        tws_pkg::ST_HOLD: begin
          if (!st_reg.ctl[tws_pkg::B_SI] && !st_reg.pend) begin
            if (st_reg.mst && st_reg.ctl[tws_pkg::B_STO]) begin
              st_next.fsm = tws_pkg::ST_STOP1;
              st_next.sda_lo = 1'b1;
            end else if (st_reg.mst && st_reg.ctl[tws_pkg::B_STA]) begin
              st_next.fsm = tws_pkg::ST_RS1;
              st_next.sda_lo = 1'b0;
            end else if (st_reg.mst) begin
              st_next.fsm = tws_pkg::ST_M_LOW;
              st_next.bitc = 4'h0;
              st_next.sda_lo = st_reg.trx && !st_reg.shf[7];
            end else begin
              st_next.fsm = tws_pkg::ST_IDLE;
              st_next.scl_lo = 1'b0;
              st_next.bitc = 4'h0;
              st_next.sda_lo = st_reg.trx && !st_reg.shf[7];
            end
          end
        end
        tws_pkg::ST_M_LOW: begin
          if (div_tick) begin
            st_next.scl_lo = 1'b0;
            st_next.fsm = tws_pkg::ST_M_HIGH;
          end
        end
        tws_pkg::ST_M_HIGH: begin
          if (div_tick) begin
            st_next.scl_lo = 1'b1;
            st_next.fsm = tws_pkg::ST_M_LOW;
          end
        end
        tws_pkg::ST_RS1: begin
          if (div_tick) begin
            st_next.scl_lo = 1'b0;
            st_next.fsm = tws_pkg::ST_RS2;
          end
        end
        tws_pkg::ST_RS2: begin
          if (div_tick) begin
            st_next.sda_lo = 1'b1;
            st_next.rep = 1'b1;
            st_next.fsm = tws_pkg::ST_GEN_START;
          end
        end
        tws_pkg::ST_STOP1: begin
          // clock released, then data released once the clock has had its high half
          if (div_tick && st_reg.scl_lo) begin
            st_next.scl_lo = 1'b0;
          end else if (div_tick && st_reg.scl_s2) begin
            st_next.sda_lo = 1'b0;
            st_next.fsm = tws_pkg::ST_IDLE;
          end
        end
        default: begin
          st_next.fsm = tws_pkg::ST_IDLE;
        end
      endcase

      // ----------------------------------------------------------------
      // bit engine, clocked by edges seen on the clock line
      // ----------------------------------------------------------------
      if (engaged && (st_reg.fsm == tws_pkg::ST_IDLE || st_reg.fsm == tws_pkg::ST_M_LOW
          || st_reg.fsm == tws_pkg::ST_M_HIGH)) begin
        if (rise && st_reg.bitc < tws_pkg::BIT_ACK) begin
          st_next.shf = {st_reg.shf[6:0], st_reg.sda_s2};
          if (st_reg.mst && st_reg.trx && !st_reg.sda_lo && !st_reg.sda_s2) begin
            // another master drove low: drop out, keep shifting as slave
            st_next.mst = 1'b0;
            st_next.arb = 1'b1;
            st_next.trx = 1'b0;
            st_next.scl_lo = 1'b0;
            st_next.fsm = tws_pkg::ST_IDLE;
          end
        end else if (rise) begin
          st_next.ackbit = st_reg.sda_s2;
        end
        if (fall) begin
          st_next.bitc = st_reg.bitc + 4'h1;
          st_next.sda_lo = 1'b0;
          if (st_reg.bitc < tws_pkg::BIT_LAST) begin
            st_next.sda_lo = st_reg.trx && !st_reg.shf[7];
          end else if (st_reg.bitc == tws_pkg::BIT_LAST && !st_reg.trx) begin
            if (st_reg.addr_ph && !st_reg.mst) begin
              if ((hit_own || (hit_gc && !st_reg.shf[0])) && st_reg.ctl[tws_pkg::B_AA]) begin
                st_next.addressed = 1'b1;
                st_next.gcm = !hit_own;
                st_next.sda_lo = 1'b1;
              end
            end else if (st_reg.mst || st_reg.addressed) begin
              st_next.sda_lo = st_reg.ctl[tws_pkg::B_AA];
            end
          end else if (st_reg.bitc == tws_pkg::BIT_ACK) begin
            st_next.bitc = 4'h0;
            byte_done = 1'b1;
          end
        end
      end

      // ----------------------------------------------------------------
      // end of byte: code the state, raise the flag, stretch the clock
      // ----------------------------------------------------------------
      if (byte_done) begin
        st_next.addr_ph = 1'b0;
        if (st_reg.arb) begin
          code = tws_pkg::S_ARB_LOST;
          set_si = 1'b1;
          st_next.arb = 1'b0;
        end else if (st_reg.mst) begin
          set_si = 1'b1;
          if (st_reg.addr_ph && st_reg.shf[0]) begin
            code = ack ? tws_pkg::S_MR_SLA_ACK : tws_pkg::S_MR_SLA_NAK;
            st_next.trx = 1'b0;
          end else if (st_reg.addr_ph) begin
            code = ack ? tws_pkg::S_MT_SLA_ACK : tws_pkg::S_MT_SLA_NAK;
            st_next.trx = 1'b1;
          end else if (st_reg.trx) begin
            code = ack ? tws_pkg::S_MT_DAT_ACK : tws_pkg::S_MT_DAT_NAK;
          end else begin
            code = ack ? tws_pkg::S_MR_DAT_ACK : tws_pkg::S_MR_DAT_NAK;
            st_next.pend = 1'b1;
          end
        end else if (st_reg.addressed) begin
          set_si = 1'b1;
          if (st_reg.addr_ph) begin
            code = st_reg.gcm ? tws_pkg::S_SR_GC
              : (st_reg.shf[0] ? tws_pkg::S_ST_SLA : tws_pkg::S_SR_SLA);
            st_next.trx = st_reg.shf[0] && !st_reg.gcm;
          end else if (st_reg.trx) begin
            code = ack ? tws_pkg::S_ST_DAT_ACK : tws_pkg::S_ST_DAT_NAK;
            st_next.addressed = ack;
            st_next.trx = ack;
          end else begin
            code = st_reg.gcm ? (ack ? tws_pkg::S_SR_GCD_ACK : tws_pkg::S_SR_GCD_NAK)
              : (ack ? tws_pkg::S_SR_DAT_ACK : tws_pkg::S_SR_DAT_NAK);
            st_next.pend = 1'b1;
            st_next.addressed = ack;
          end
        end
        if (set_si) begin
          st_next.fsm = tws_pkg::ST_HOLD;
          st_next.scl_lo = 1'b1;
        end
      end

      // ----------------------------------------------------------------
      // bus conditions
      // ----------------------------------------------------------------
      if (start_det) begin
        st_next.busy = 1'b1;
        st_next.bitc = 4'h0;
        st_next.addr_ph = 1'b1;
        if (!st_reg.mst) begin
          st_next.trx = 1'b0;
          st_next.gcm = 1'b0;
        end
        if (st_reg.addressed) begin
          code = tws_pkg::S_SR_STOP;
          set_si = 1'b1;
          st_next.addressed = 1'b0;
        end
      end
      if (stop_det) begin
        st_next.busy = 1'b0;
        st_next.bitc = 4'h0;
        st_next.addr_ph = 1'b0;
        st_next.ctl[tws_pkg::B_STO] = 1'b0;
        st_next.mst = 1'b0;
        st_next.trx = 1'b0;
        if (st_reg.addressed) begin
          code = tws_pkg::S_SR_STOP;
          set_si = 1'b1;
          st_next.addressed = 1'b0;
        end
      end
      // slave recovery: behave as after a STOP without driving one
      if (st_reg.ctl[tws_pkg::B_STO] && !st_reg.mst && st_reg.fsm != tws_pkg::ST_GEN_START) begin
        st_next.ctl[tws_pkg::B_STO] = 1'b0;
        st_next.addressed = 1'b0;
        st_next.addr_ph = 1'b0;
        st_next.arb = 1'b0;
        st_next.trx = 1'b0;
        st_next.bitc = 4'h0;
        st_next.sda_lo = 1'b0;
        st_next.scl_lo = 1'b0;
        st_next.fsm = tws_pkg::ST_IDLE;
      end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    fifo_pop = sfr_req.rd && sfr_req.addr == tws_pkg::ADDR_DAT && fifo_out_valid;
    if (sfr_req.rd) begin
      if (sfr_req.addr == tws_pkg::ADDR_CTL) begin
        st_next.rdata = st_reg.ctl;
      end else if (sfr_req.addr == tws_pkg::ADDR_STA) begin
        st_next.rdata = st_reg.ctl[tws_pkg::B_SI] ? {st_reg.sc, 3'h0}
          : tws_pkg::S_IDLE;
      end else if (sfr_req.addr == tws_pkg::ADDR_DAT) begin
        st_next.rdata = fifo_out_valid ? fifo_out_data : st_reg.shf;
      end else if (sfr_req.addr == tws_pkg::ADDR_ADR) begin
        st_next.rdata = st_reg.adr;
      end else begin
        st_next.rdata = 8'h00;
      end
    end
    if (sfr_req.wr) begin
      if (sfr_req.addr == tws_pkg::ADDR_CTL) begin
        st_next.ctl = sfr_req.wdata;
        st_next.ctl[tws_pkg::B_SI] = st_reg.ctl[tws_pkg::B_SI] && sfr_req.wdata[tws_pkg::B_SI];
      end else if (sfr_req.addr == tws_pkg::ADDR_DAT) begin
        st_next.shf = sfr_req.wdata;
      end else if (sfr_req.addr == tws_pkg::ADDR_ADR) begin
        st_next.adr = sfr_req.wdata;
      end
    end
    // a hardware event beats a software clear in the same cycle
    if (set_si) begin
      st_next.ctl[tws_pkg::B_SI] = 1'b1;
      st_next.sc = code[7:tws_pkg::SC_LSB];
    end

    // port latch low still pulls the shared pin, as a plain port bit would
    st_next.sda_oe = (st_next.ctl[tws_pkg::B_ENS] && st_next.sda_lo) || !port_sda_latch;
    st_next.scl_oe = (st_next.ctl[tws_pkg::B_ENS] && st_next.scl_lo) || !port_scl_latch;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata = st_reg.rdata;
  assign sda_out = st_reg.pin_lvl;
  assign scl_out = st_reg.pin_lvl;
  assign sda_oe = st_reg.sda_oe;
  assign scl_oe = st_reg.scl_oe;

endmodule : tws_two_wire_unit

// ---- verif/tws_two_wire_unit_monitor.sv ----
module tws_two_wire_unit_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire tws_pkg::tws_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic port_sda_latch,
  input wire logic port_scl_latch,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // enable history, three deep so the registered pins settle
  // ----
  logic [2:0] ens_reg;
  wire ctl_wr = sfr_req.wr && sfr_req.addr == 8'hD8;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ens_reg <= 3'h0;
    end else begin
      ens_reg <= {ens_reg[1:0], ctl_wr ? sfr_req.wdata[6] : ens_reg[0]};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("sda_out high");
  a_scl_out_low: assert property (scl_out == 1'b0)
    else $error("scl_out high");
  a_off_sda_port: assert property (ens_reg == 3'h0 && $stable(port_sda_latch)
    |-> sda_oe == !port_sda_latch) else $error("sda not port bit");
  a_off_scl_port: assert property (ens_reg == 3'h0 && $stable(port_scl_latch)
    |-> scl_oe == !port_scl_latch) else $error("scl not port bit");
  a_status_low_zero: assert property (sfr_req.rd && sfr_req.addr == 8'hD9
    |=> sfr_rdata[2:0] == 3'h0) else $error("status low bits set");
  a_unmapped_zero: assert property (sfr_req.rd && sfr_req.addr > 8'hDB
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_addr_readback: assert property (sfr_req.wr && sfr_req.addr == 8'hDB ##1
    sfr_req.rd && sfr_req.addr == 8'hDB |=> sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("address register lost");
  a_rdata_holds: assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata))
    else $error("read data moved");
endmodule : tws_two_wire_unit_monitor
bind tws_two_wire_unit tws_two_wire_unit_monitor mon (.clk, .rstn, .sfr_req, .sfr_rdata,
  .port_sda_latch, .port_scl_latch, .sda_in, .sda_out, .sda_oe, .scl_in, .scl_out, .scl_oe);

// ---- verif/tws_slave_model.sv ----
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h5A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic sda_oe,
  output logic scl_oe,
  output logic [7:0] rx_byte,
  output logic got
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic first = 0;
  logic [7:0] sh = 0;
  initial begin
    sda_oe = 0;
    scl_oe = 0;
    rx_byte = 0;
    got = 0;
  end
  always @(negedge sda) if (scl) {cnt, first} = {32'd0, 1'b1};
  always @(posedge sda) if (scl) cnt = 0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    cnt++;
  end
  // ack own address and every data byte; slow mode stretches the clock after it
  always @(negedge scl) begin
    if (cnt == 8) begin
      sda_oe = !first || sh[7:1] == ADDR;
      rx_byte = sh;
      got = !first;
    end else if (cnt == 9) begin
      {sda_oe, got, first, cnt} = '0;
      if (slow) begin
        scl_oe = 1;
        #2000 scl_oe = 0;
      end
    end
  end
endmodule : tws_slave_model

// ---- verif/tws_two_wire_unit_tb_top.sv ----
module tws_two_wire_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, lat = 1, slow = 0, pend = 0;
  tws_pkg::tws_sfr_req_t req = '0;
  logic [7:0] rdata, v, d, rx;
  logic sda_oe, scl_oe, m_sda, m_scl, got;
  wire sda = !(sda_oe || m_sda);
  wire scl = !(scl_oe || m_scl);
  int fail_count = 0, checks = 0;
  logic [7:0] q[$], bq[$];
  always #2 clk = ~clk;
  tws_two_wire_unit uut (.clk, .rstn, .sfr_req(req), .sfr_rdata(rdata), .port_sda_latch(lat),
    .port_scl_latch(lat), .sda_in(sda), .sda_out(), .sda_oe, .scl_in(scl), .scl_out(), .scl_oe);
  tws_slave_model sm (.scl, .sda, .slow, .sda_oe(m_sda), .scl_oe(m_scl), .rx_byte(rx), .got);
  task automatic cmp(logic [7:0] g, logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic op(logic w, logic [7:0] a, logic [7:0] wd);
    @(negedge clk);
    req = '{a, w, !w, wd};
  endtask : op
  task automatic wr(logic [7:0] a, logic [7:0] wd);
    op(1, a, wd);
    @(negedge clk);
    req.wr = 0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    op(0, a, 8'h00);
    @(negedge clk);
    req.rd = 0;
    v = rdata;
  endtask : rd
  task automatic chk(logic [7:0] a, logic [7:0] e);
    q.push_back(e);
    rd(a);
  endtask : chk
  task automatic poll(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    int n = 0;
    do begin
      rd(a);
      n++;
    end while ((v & m) === e && n < 3000);
    if ((v & m) === e) begin
      fail_count++;
      $display("ERROR t=%0t poll stuck got=%h exp=%h", $time, v & m, ~e & m);
    end
  endtask : poll
  task automatic results;
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  always @(posedge clk) pend <= req.rd && q.size() > 0;
  always @(negedge clk) if (pend) cmp(rdata, q.pop_front());
  always @(posedge got) cmp(rx, bq.pop_front());
  initial begin
    #300000;
    fail_count++;
    results;
  end
  initial begin
    void'($urandom(65));
    repeat (4) @(negedge clk);
    rstn = 1;
    chk(8'hD9, 8'hF8);
    chk(8'hD8, 8'h00);
    chk(8'hDC, 8'h00);
    d = 8'($urandom) & 8'h7F;
    op(1, 8'hDB, d);
    chk(8'hDB, d);
    // pass 0 addresses the model and sends data, pass 1 gets a refused address
    for (int i = 0; i < 2; i++) begin
      slow = (i == 0);
      d = 8'($urandom);
      wr(8'hD8, 8'hE2);
      poll(8'hD9, 8'hFF, 8'hF8);
      chk(8'hD9, 8'h08);
      wr(8'hDA, {7'h5A ^ 7'(i), 1'b0});
      wr(8'hD8, 8'hC6);
      poll(8'hD9, 8'hFF, 8'hF8);
      chk(8'hD9, i ? 8'h20 : 8'h18);
      if (i == 0) begin
        bq.push_back(d);
        wr(8'hDA, d);
        wr(8'hD8, 8'hC6);
        poll(8'hD9, 8'hFF, 8'hF8);
        chk(8'hD9, 8'h28);
        wr(8'hD8, 8'hE6);
        poll(8'hD9, 8'hFF, 8'hF8);
        chk(8'hD9, 8'h10);
      end
      wr(8'hD8, 8'hD6);
      poll(8'hD8, 8'h10, 8'h10);
      chk(8'hD9, 8'hF8);
    end
    // master receive at another rate: released line reads ones, byte lands in the queue
    bq.push_back(8'hFF);
    wr(8'hD8, 8'hE1);
    poll(8'hD9, 8'hFF, 8'hF8);
    wr(8'hDA, {7'h5A, 1'b1});
    wr(8'hD8, 8'hC5);
    poll(8'hD9, 8'hFF, 8'hF8);
    chk(8'hD9, 8'h40);
    wr(8'hD8, 8'hC5);
    poll(8'hD9, 8'hFF, 8'hF8);
    chk(8'hD9, 8'h50);
    chk(8'hDA, 8'hFF);
    wr(8'hD8, 8'hD5);
    poll(8'hD8, 8'h10, 8'h10);
    wr(8'hD8, 8'h00);
    repeat (4) @(negedge clk);
    lat = 0;
    repeat (6) @(negedge clk);
    lat = 1;
    repeat (6) @(negedge clk);
    results;
  end
endmodule : tws_two_wire_unit_tb_top
